//--- smi_pkg.sv
// Package for the supply monitor interrupt block
package smi_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] SMI_CTRL_ADDR = 8'hDF;
	localparam logic [7:0] SMI_CTRL_RESET = 8'hDE;
	localparam int SMI_BIT_DOK = 7;
	localparam int SMI_BIT_AOK = 6;
	localparam int SMI_BIT_FLAG = 5;
	localparam int SMI_DSEL_HI = 4;
	localparam int SMI_DSEL_LO = 3;
	localparam int SMI_ASEL_HI = 2;
	localparam int SMI_ASEL_LO = 1;
	localparam int SMI_BIT_ON = 0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint SMI_CLK_HZ = 25000000;
	localparam longint SMI_RECOVER_MS = 250;
	localparam longint SMI_RECOVER_CYC = SMI_CLK_HZ * SMI_RECOVER_MS / 1000;
	localparam int SMI_CNT_W = 24;
	localparam int SMI_GLITCH_CYC = 4;
	localparam int SMI_GF_W = 3;
	// ----------------------------------------
	// Trip select codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		SMI_TRIP_4V63 = 2'h0,
		SMI_TRIP_3V08 = 2'h1,
		SMI_TRIP_2V93 = 2'h2,
		SMI_TRIP_2V63 = 2'h3
	} smi_trip_t;
	// SFR bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smi_sfr_req_t;
	// Comparator pair
	typedef struct packed {
		logic digital_ok;
		logic analog_ok;
	} smi_cmp_t;
endpackage : smi_pkg

//--- smi_top.sv
// Supply monitor control register, flag and recovery timer
`timescale 1ns/1ps
// Overview of operation
// - Monitor runs only while control bit 0 is set; writing 0 disables it.
// - Bit 7 reads the digital supply comparator, 1 means above trip.
// - Bit 6 reads the analog supply comparator, 1 means above trip.
// - Flag bit 5 is set whenever either comparator is low while the monitor is on.
// - Both comparators high starts 250 ms count; expiry clears the flag.
// - Software may write the flag, but cannot clear it while any is low.
// - Flag raises the core interrupt when its enable bit is set.
// - Bits 4:3 select digital trip point: 4.63, 3.08, 2.93, 2.63 V.
// - Bits 2:1 select analog trip point with the same encoding.
// - Control register at DFH, resets to DEH, not bit-addressable.
// - Short comparator glitches are filtered and do not set the flag.
module smi_top (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// SFR access
	input wire smi_pkg::smi_sfr_req_t sfr_req_i,
	output logic [7:0] sfr_rdata_o,
	// Analog comparators
	input wire smi_pkg::smi_cmp_t cmp_i,
	output smi_pkg::smi_trip_t dig_trip_o,
	output smi_pkg::smi_trip_t ana_trip_o,
	output logic monitor_on_o,
	// Core interrupt
	input wire logic irq_enable_i,
	output logic irq_o
);
	import smi_pkg::*;

	// Trip code from a two-bit select field
	function automatic smi_trip_t trip_of(input logic [1:0] field);
		return smi_trip_t'(field);
	endfunction : trip_of

	// ----------------------------------------
	// Comparator synchronisers and filter
	// ----------------------------------------
	smi_cmp_t cmp_meta_reg, cmp_sync_reg;
	smi_cmp_t cmp_filt_reg;
	logic [SMI_GF_W-1:0] gf_cnt_reg;
	logic ctrl_wr;
	logic [7:0] ctrl_reg;
	logic flag_reg;
	logic [SMI_CNT_W-1:0] rec_cnt_reg;
	logic any_low;
	logic rec_done;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			// Reset to ok so power-up does not fake a low supply
			cmp_meta_reg <= '1;
			cmp_sync_reg <= '1;
		end else begin
			cmp_meta_reg <= cmp_i;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// Change accepted only after a stable run; a pulse shorter is dropped
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			gf_cnt_reg <= '0;
			cmp_filt_reg <= '1;
		end else if (cmp_sync_reg == cmp_filt_reg) begin
			gf_cnt_reg <= '0;
		end else if (gf_cnt_reg == SMI_GF_W'(SMI_GLITCH_CYC - 1)) begin
			gf_cnt_reg <= '0;
			cmp_filt_reg <= cmp_sync_reg;
		end else begin
			gf_cnt_reg <= gf_cnt_reg + 1'b1;
		end
	end

	assign any_low = ctrl_reg[SMI_BIT_ON] &&
		!(cmp_filt_reg.digital_ok && cmp_filt_reg.analog_ok);
	assign ctrl_wr = sfr_req_i.wr && (sfr_req_i.addr == SMI_CTRL_ADDR);

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	// Whole-byte write only, no bit addressing
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			ctrl_reg <= SMI_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= sfr_req_i.wdata;
		end
	end

	// ----------------------------------------
	// Recovery counter
	// ----------------------------------------
	// Counts only while a raised flag waits for both supplies
	assign rec_done = rec_cnt_reg == SMI_CNT_W'(SMI_RECOVER_CYC - 1);

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || any_low || !flag_reg) begin
			rec_cnt_reg <= '0;
		end else if (!rec_done) begin
			rec_cnt_reg <= rec_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// Interrupt flag
	// ----------------------------------------
	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			flag_reg <= 1'b0;
		end else if (any_low) begin
			flag_reg <= 1'b1;
		end else if (ctrl_wr) begin
			flag_reg <= sfr_req_i.wdata[SMI_BIT_FLAG];
		end else if (flag_reg && rec_done) begin
			flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			// Follows the control reset byte, so no step after release
			sfr_rdata_o <= SMI_CTRL_RESET;
			irq_o <= 1'b0;
			dig_trip_o <= trip_of(SMI_CTRL_RESET[SMI_DSEL_HI:SMI_DSEL_LO]);
			ana_trip_o <= trip_of(SMI_CTRL_RESET[SMI_ASEL_HI:SMI_ASEL_LO]);
			monitor_on_o <= SMI_CTRL_RESET[SMI_BIT_ON];
		end else begin
			sfr_rdata_o <= {cmp_filt_reg.digital_ok,
				cmp_filt_reg.analog_ok, flag_reg,
				ctrl_reg[SMI_DSEL_HI:SMI_BIT_ON]};
			irq_o <= flag_reg && irq_enable_i;
			dig_trip_o <= trip_of(ctrl_reg[SMI_DSEL_HI:SMI_DSEL_LO]);
			ana_trip_o <= trip_of(ctrl_reg[SMI_ASEL_HI:SMI_ASEL_LO]);
			monitor_on_o <= ctrl_reg[SMI_BIT_ON];
		end
	end

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	logic sync_diff;
	logic [1:0] wr_dsel;
	logic [1:0] wr_asel;
	logic wr_flag;
	logic [SMI_DSEL_HI:SMI_BIT_ON] ctrl_fields;
	assign sync_diff = cmp_sync_reg != cmp_filt_reg;
	assign wr_dsel = sfr_req_i.wdata[SMI_DSEL_HI:SMI_DSEL_LO];
	assign wr_asel = sfr_req_i.wdata[SMI_ASEL_HI:SMI_ASEL_LO];
	assign wr_flag = sfr_req_i.wdata[SMI_BIT_FLAG];
	assign ctrl_fields = ctrl_reg[SMI_DSEL_HI:SMI_BIT_ON];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking smi_cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Flag, counter and interrupt
	a_flag_sets_low: assert property (any_low |=> flag_reg)
		else $error("flag not set on low supply");
	a_clear_blocked: assert property (
		(any_low && ctrl_wr) |=> flag_reg)
		else $error("clear not blocked");
	a_sw_flag_write: assert property (
		(ctrl_wr && !any_low) |=> flag_reg == $past(wr_flag))
		else $error("flag write not taken");
	a_counter_held: assert property (any_low |=> rec_cnt_reg == '0)
		else $error("counter not held");
	a_counter_runs: assert property (
		(flag_reg && !any_low && !rec_done)
		|=> rec_cnt_reg == $past(rec_cnt_reg) + 1'b1)
		else $error("counter not counting");
	a_auto_clear: assert property (
		(flag_reg && rec_done && !any_low && !ctrl_wr) |=> !flag_reg)
		else $error("flag not cleared at expiry");
	a_no_early_clear: assert property (
		(flag_reg && !rec_done && !ctrl_wr) |=> flag_reg)
		else $error("flag cleared early");
	a_off_no_set: assert property (
		(!ctrl_reg[SMI_BIT_ON] && !flag_reg && !ctrl_wr) |=> !flag_reg)
		else $error("flag set while disabled");
	a_irq_follows: assert property (
		irq_o == ($past(flag_reg) && $past(irq_enable_i)))
		else $error("irq mismatch");

	// Filter and register view
	a_glitch_drop: assert property (
		$changed(cmp_filt_reg) |-> $past(sync_diff, 1) && $past(sync_diff, 2)
		&& $past(sync_diff, 3) && $past(sync_diff, 4))
		else $error("glitch passed");
	a_ctrl_write: assert property (
		ctrl_wr |=> ctrl_reg == $past(sfr_req_i.wdata))
		else $error("control write lost");
	a_other_addr: assert property (
		(sfr_req_i.wr && sfr_req_i.addr != SMI_CTRL_ADDR)
		|=> $stable(ctrl_reg))
		else $error("foreign write landed");
	a_trip_map: assert property (
		ctrl_wr |=> ##1 dig_trip_o == trip_of($past(wr_dsel, 2)))
		else $error("trip select mismatch");
	a_ana_trip_map: assert property (
		ctrl_wr |=> ##1 ana_trip_o == trip_of($past(wr_asel, 2)))
		else $error("analog trip select mismatch");
	a_on_follows: assert property (
		monitor_on_o == $past(ctrl_reg[SMI_BIT_ON]))
		else $error("enable output mismatch");
	a_rdata_view: assert property (
		sfr_rdata_o[SMI_BIT_DOK:SMI_BIT_AOK] == $past(cmp_filt_reg))
		else $error("comparator view mismatch");
	a_rdata_flag: assert property (
		sfr_rdata_o[SMI_BIT_FLAG] == $past(flag_reg))
		else $error("flag view mismatch");
	a_rdata_fields: assert property (
		sfr_rdata_o[SMI_DSEL_HI:SMI_BIT_ON] == $past(ctrl_fields))
		else $error("field view mismatch");

	// Main scenarios
	c_low_event: cover property ($rose(flag_reg));
	c_auto_clear: cover property ($fell(flag_reg) && !$past(ctrl_wr));
	c_blocked_clear: cover property (
		any_low && ctrl_wr && !sfr_req_i.wdata[SMI_BIT_FLAG]);
	c_glitch_held: cover property ((gf_cnt_reg != '0) && !sync_diff);
endmodule : smi_top

//--- smi_supply_model.sv
// Comparator pair model for the two supplies
`timescale 1ns/1ps
module smi_supply_model (
	// Trip selection
	input wire smi_pkg::smi_trip_t dig_trip_i,
	input wire smi_pkg::smi_trip_t ana_trip_i,
	// Supply levels in mV
	input wire logic [12:0] dvdd_mv_i,
	input wire logic [12:0] avdd_mv_i,
	// Comparator outputs
	output smi_pkg::smi_cmp_t cmp_o
);
	import smi_pkg::*;
	function automatic logic [12:0] trip_mv(smi_trip_t s);
		case (s)
			SMI_TRIP_4V63: return 13'h1216;
			SMI_TRIP_3V08: return 13'h0C08;
			SMI_TRIP_2V93: return 13'h0B72;
			default: return 13'h0A46;
		endcase
	endfunction : trip_mv
	// Ideal comparators, no hysteresis
	assign cmp_o.digital_ok = dvdd_mv_i > trip_mv(dig_trip_i);
	assign cmp_o.analog_ok = avdd_mv_i > trip_mv(ana_trip_i);
endmodule : smi_supply_model

//--- supply_monitor_interrupt_test.sv
// Self-checking bench for the supply monitor block
`timescale 1ns/1ps
module supply_monitor_interrupt_test;
	import smi_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic irq_en = 1'b1;
	smi_sfr_req_t req = '0;
	smi_cmp_t cmp;
	smi_trip_t dtrip;
	smi_trip_t atrip;
	logic [7:0] rd;
	logic on;
	logic irq;
	logic [12:0] dmv = 13'h0CE4;
	logic [12:0] amv = 13'h0CE4;
	int fails = 0;
	int comparisons = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	smi_top smi_top_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.sfr_req_i(req), .sfr_rdata_o(rd), .cmp_i(cmp), .dig_trip_o(dtrip),
		.ana_trip_o(atrip), .monitor_on_o(on), .irq_enable_i(irq_en),
		.irq_o(irq));
	smi_supply_model smi_supply_model_inst (.dig_trip_i(dtrip),
		.ana_trip_i(atrip), .dvdd_mv_i(dmv), .avdd_mv_i(amv), .cmp_o(cmp));
	task automatic run(int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask : run
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		run(1);
		req.wr = 1'b0;
		run(3);
	endtask : wr
	task automatic t_regs();
		// Supplies above every trip point, so no flag is raised here
		dmv = 13'h1388;
		amv = 13'h1388;
		chk("ctrl", rd, SMI_CTRL_RESET);
		chk("on", on, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(SMI_CTRL_ADDR, {3'h0, i[1:0], i[1:0], 1'b1});
			chk("dsel", dtrip, i[1:0]);
			chk("asel", atrip, i[1:0]);
			chk("on", on, 8'h01);
		end
		// Unmapped write must leave the register alone
		wr(8'hDE, 8'h00);
		chk("ctrl", rd, 8'hDF);
		dmv = 13'h0CE4;
		amv = 13'h0CE4;
		$display("regs done");
	endtask : t_regs
	task automatic t_low();
		dmv = 13'h09C4;
		run(3);
		dmv = 13'h0CE4;
		run(12);
		chk("glitch", rd[5], 8'h00);
		dmv = 13'h09C4;
		run(12);
		chk("dok", rd[7], 8'h00);
		chk("flag", rd[5], 8'h01);
		chk("irq", irq, 8'h01);
		irq_en = 1'b0;
		run(3);
		chk("irq", irq, 8'h00);
		irq_en = 1'b1;
		wr(SMI_CTRL_ADDR, 8'h1F);
		chk("flag", rd[5], 8'h01);
		dmv = 13'h0CE4;
		amv = 13'h09C4;
		run(12);
		chk("aok", rd[7:6], 8'h02);
		amv = 13'h0CE4;
		run(12);
		chk("hold", rd[5], 8'h01);
		wr(SMI_CTRL_ADDR, 8'h1F);
		chk("flag", rd[5], 8'h00);
		// Monitor off: a low supply must not set the flag
		wr(SMI_CTRL_ADDR, 8'h1E);
		dmv = 13'h09C4;
		run(12);
		chk("off", rd[5], 8'h00);
		$display("low done");
	endtask : t_low
	task automatic t_reset();
		dmv = 13'h0CE4;
		rstn_i = 1'b0;
		run(2);
		chk("rst ctrl", rd, SMI_CTRL_RESET);
		chk("rst dsel", dtrip, SMI_CTRL_RESET[SMI_DSEL_HI:SMI_DSEL_LO]);
		chk("rst asel", atrip, SMI_CTRL_RESET[SMI_ASEL_HI:SMI_ASEL_LO]);
		rstn_i = 1'b1;
		run(2);
		chk("rst ctrl", rd, SMI_CTRL_RESET);
		chk("rst on", on, 8'h00);
		$display("reset done");
	endtask : t_reset
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	initial begin
		run(16);
		rstn_i = 1'b1;
		run(2);
		t_regs();
		t_low();
		t_reset();
		close_out();
	end
endmodule : supply_monitor_interrupt_test
